// file: logic/vou_pkg.sv
// Constants and types for the video output unit
package vou_pkg;
   // Register byte addresses
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_FRAME = 6'h04;
   localparam logic [5:0] A_FIELD = 6'h08;
   localparam logic [5:0] A_VLINE = 6'h0c;
   localparam logic [5:0] A_IRQLN = 6'h10;
   localparam logic [5:0] A_SYNTH = 6'h14;
   localparam logic [5:0] A_ALPHA = 6'h18;
   localparam logic [5:0] A_MSG = 6'h1c;
   localparam logic [5:0] A_STAT = 6'h20;
   // Field placement inside registers
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 16;
   localparam int NUM_W = 12;
   localparam int CTRL_W = 15;
   localparam int MSG_W = 23;
   localparam int ALPHA_W = 8;
   localparam int ST_FIELD = 16;
   localparam int ST_MSG = 17;
   localparam int ST_HOLD = 18;
   // Reset geometry, a 525-line frame
   localparam logic [11:0] RST_LINES = 12'h20d;
   localparam logic [11:0] RST_LBYTES = 12'h6b4;
   localparam logic [11:0] RST_F2 = 12'h10a;
   localparam logic [11:0] RST_HS = 12'h110;
   localparam logic [11:0] RST_F1V = 12'h014;
   localparam logic [11:0] RST_F2V = 12'h11b;
   localparam logic [11:0] FIRST_LINE = 12'h001;
   localparam logic [11:0] UNIT12 = 12'h001;
   localparam logic [11:0] CODE_LEN = 12'h004;
   // Sync preamble, code position, blanking levels
   localparam logic [7:0] SYNC_FF = 8'hff;
   localparam logic [7:0] SYNC_00 = 8'h00;
   localparam logic [7:0] BLANK_C = 8'h80;
   localparam logic [7:0] BLANK_Y = 8'h10;
   localparam logic [1:0] FF_POS = 2'h0;
   localparam logic [1:0] Y0_POS = 2'h1;
   localparam logic [1:0] V_POS = 2'h2;
   localparam logic [1:0] LAST_POS = 2'h3;
   // Synthesizer
   localparam int JIT_BIT = 31;
   localparam logic [34:0] LOW_JIT_MUL = 35'h9;
   localparam logic [34:0] LEGACY_MUL = 35'h3;
   localparam logic [31:0] STEP_CAP = 32'h7fffffff;
   localparam logic [1:0] PLL_PASS = 2'h0;
   localparam logic [1:0] PLL_DOUBLE = 2'h1;
   localparam logic [1:0] PLL_HALF = 2'h2;
   // Blending
   localparam logic [8:0] ALPHA_ONE = 9'h080;
   localparam int BLEND_SH = 7;

   typedef struct packed {
      logic [1:0] pll_mode;
      logic irq_line_en;
      logic irq_field_en;
      logic overlay_en;
      logic upscale;
      logic fs_rising;
      logic fs_out_en;
      logic hs_out_en;
      logic loopback_select;
      logic clock_direction_bit;
      logic genlock;
      logic timing_master;
      logic msg_mode;
      logic enable;
   } vou_ctrl_type;

   typedef struct packed {
      logic [7:0] u;
      logic [7:0] y0;
      logic [7:0] v;
      logic [7:0] y1;
   } vou_pix_type;

   typedef struct packed {
      logic alpha;
      vou_pix_type pix;
   } vou_ovl_type;

   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_SEND = 3'b010,
      M_DONE = 3'b100
   } vou_msg_state_type;
endpackage

// file: logic/vou_video_output_unit.sv
// Video output unit: registers, clock synthesis, timing and byte stream
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Sends 4:2:2 bytes with embedded sync codes
// - Frames up to 4095 lines, 4095 bytes per line
// - Byte rate from 27 MB/s to 81 MHz
// - Alpha bit picks one of two factors
// - Optional 2x horizontal video doubling
// - Messages one word up to 32 MB
// - Loopback routes output to video input
// - Interrupt at field start and/or line
// - Codes always; sync pins only when enabled
// - Pin one: line sync or message start
// - Pin two: frame sync in/out, message end
// - Each frame sync edge sends two fields
// - External timing only when select0, lock1
// - All outputs launched on video clock edge
// - Clock pin input after reset, else output
// - Output clock programmable about 4-81 MHz
// - Synthesizer spans 1 Hz to 50 MHz
// - Bit 31 set: low-jitter, times nine
// - Bit 31 clear: legacy, times three
// - Cleanup stage passes, doubles or halves
// - No vertical retrace timing produced
// - Codes preceded by FF 00 00 preamble
module vou_video_output_unit #(
   parameter int MSG_W = vou_pkg::MSG_W
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [5:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire vou_pkg::vou_pix_type pix_in,
   input wire vou_pkg::vou_ovl_type ovl_in,
   output logic pix_take,
   output logic ovl_take,
   output logic [7:0] video_byte_bus,
   input wire logic video_clock_pin_i,
   output logic video_clock_pin_o,
   output logic video_clock_pin_oe,
   output logic line_sync_or_msg_start_pin_o,
   output logic line_sync_or_msg_start_pin_oe,
   input wire logic frame_sync_or_msg_end_pin_i,
   output logic frame_sync_or_msg_end_pin_o,
   output logic frame_sync_or_msg_end_pin_oe,
   output logic [7:0] loop_byte,
   output logic loop_valid,
   output logic host_irq
);
   if (MSG_W < vou_pkg::MSG_W || MSG_W > 32) begin : g_chk
      $error("MSG_W must lie between 23 and 32");
   end

   vou_pkg::vou_ctrl_type ctrl;
   vou_pkg::vou_msg_state_type state;
   logic [11:0] frame_lines, line_bytes, field2_start, hs_start;
   logic [11:0] f1_vline, f2_vline, irq_line, hcnt, lcnt, sidx, aidx;
   logic [31:0] synth_inc, step, phase;
   logic [34:0] step_raw;
   logic [7:0] alpha0, alpha1, next_byte, vidb, ovb, active_byte, msg_byte, code;
   logic [8:0] a9;
   logic [16:0] mix;
   logic [MSG_W-1:0] msg_words, words_left;
   logic [1:0] bpos, pre_idx;
   logic msg_go, dds_sq, dds_prev, half_sq, int_tick, clk_q, clk_q2, vtick;
   logic ext_lock, hold, fs_q, fs_edge, field, vblank, in_eav, in_sav, in_act;
   logic line_end, frame_end, run, pair_end, dbl_half, is_code, code_out, msg_last;

   // Word packing of two 12-bit fields
   function automatic logic [31:0] pack2(input logic [11:0] lo, input logic [11:0] hi);
      pack2 = (32'(hi) << vou_pkg::HI_LSB) | (32'(lo) << vou_pkg::LO_LSB);
   endfunction

   // Register writes; a length write also launches a message
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= '0;
         frame_lines <= vou_pkg::RST_LINES;
         line_bytes <= vou_pkg::RST_LBYTES;
         field2_start <= vou_pkg::RST_F2;
         hs_start <= vou_pkg::RST_HS;
         f1_vline <= vou_pkg::RST_F1V;
         f2_vline <= vou_pkg::RST_F2V;
         irq_line <= vou_pkg::FIRST_LINE;
         synth_inc <= '0;
         alpha0 <= '0;
         alpha1 <= '0;
         msg_words <= '0;
         msg_go <= 1'b0;
      end else begin
         msg_go <= 1'b0;
         if (reg_wr) begin
            case (reg_addr)
               vou_pkg::A_CTRL: ctrl <= vou_pkg::vou_ctrl_type'(reg_wdata[vou_pkg::CTRL_W-1:0]);
               vou_pkg::A_FRAME: begin
                  frame_lines <= reg_wdata[vou_pkg::LO_LSB +: vou_pkg::NUM_W];
                  line_bytes <= reg_wdata[vou_pkg::HI_LSB +: vou_pkg::NUM_W];
               end
               vou_pkg::A_FIELD: begin
                  field2_start <= reg_wdata[vou_pkg::LO_LSB +: vou_pkg::NUM_W];
                  hs_start <= reg_wdata[vou_pkg::HI_LSB +: vou_pkg::NUM_W];
               end
               vou_pkg::A_VLINE: begin
                  f1_vline <= reg_wdata[vou_pkg::LO_LSB +: vou_pkg::NUM_W];
                  f2_vline <= reg_wdata[vou_pkg::HI_LSB +: vou_pkg::NUM_W];
               end
               vou_pkg::A_IRQLN: irq_line <= reg_wdata[vou_pkg::LO_LSB +: vou_pkg::NUM_W];
               vou_pkg::A_SYNTH: synth_inc <= reg_wdata;
               vou_pkg::A_ALPHA: begin
                  alpha0 <= reg_wdata[vou_pkg::LO_LSB +: vou_pkg::ALPHA_W];
                  alpha1 <= reg_wdata[vou_pkg::ALPHA_W +: vou_pkg::ALPHA_W];
               end
               vou_pkg::A_MSG: begin
                  msg_words <= reg_wdata[MSG_W-1:0];
                  msg_go <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            vou_pkg::A_CTRL: reg_rdata <= 32'(ctrl);
            vou_pkg::A_FRAME: reg_rdata <= pack2(frame_lines, line_bytes);
            vou_pkg::A_FIELD: reg_rdata <= pack2(field2_start, hs_start);
            vou_pkg::A_VLINE: reg_rdata <= pack2(f1_vline, f2_vline);
            vou_pkg::A_IRQLN: reg_rdata <= 32'(irq_line);
            vou_pkg::A_SYNTH: reg_rdata <= synth_inc;
            vou_pkg::A_ALPHA: reg_rdata <= 32'({alpha1, alpha0});
            vou_pkg::A_MSG: reg_rdata <= 32'(msg_words);
            vou_pkg::A_STAT: begin
               reg_rdata <= 32'(lcnt);
               reg_rdata[vou_pkg::ST_FIELD] <= field;
               reg_rdata[vou_pkg::ST_MSG] <= state == vou_pkg::M_SEND;
               reg_rdata[vou_pkg::ST_HOLD] <= hold;
            end
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Phase step: low-jitter nine-times or legacy three-times rate
   always_comb begin
      if (synth_inc[vou_pkg::JIT_BIT]) begin
         step_raw = 35'(synth_inc[vou_pkg::JIT_BIT-1:0]) * vou_pkg::LOW_JIT_MUL;
      end else begin
         step_raw = 35'(synth_inc) * vou_pkg::LEGACY_MUL;
      end
      step = (step_raw > 35'(vou_pkg::STEP_CAP)) ? vou_pkg::STEP_CAP : step_raw[31:0];
   end

   // Square-wave phase accumulator and divide stage
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= '0;
         dds_sq <= 1'b0;
         dds_prev <= 1'b0;
         half_sq <= 1'b0;
      end else begin
         phase <= phase + step;
         dds_sq <= phase[vou_pkg::JIT_BIT];
         dds_prev <= dds_sq;
         if (dds_sq && !dds_prev) begin
            half_sq <= ~half_sq;
         end
      end
   end

   // Cleanup stage: pass, both edges, or every second edge
   always_comb begin
      case (ctrl.pll_mode)
         vou_pkg::PLL_DOUBLE: int_tick = dds_sq ^ dds_prev;
         vou_pkg::PLL_HALF: int_tick = dds_sq && !dds_prev && half_sq;
         default: int_tick = dds_sq && !dds_prev;
      endcase
   end

   // External clock pin sampling for rising edges
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         clk_q <= 1'b0;
         clk_q2 <= 1'b0;
         fs_q <= 1'b0;
      end else begin
         clk_q <= video_clock_pin_i;
         clk_q2 <= clk_q;
         fs_q <= frame_sync_or_msg_end_pin_i;
      end
   end

   // Byte enable from chosen clock source
   assign vtick = ctrl.enable && (ctrl.clock_direction_bit ? int_tick : (clk_q && !clk_q2));
   assign ext_lock = !ctrl.timing_master && ctrl.genlock;
   assign fs_edge = ctrl.fs_rising ? (frame_sync_or_msg_end_pin_i && !fs_q)
                                   : (!frame_sync_or_msg_end_pin_i && fs_q);
   assign run = ctrl.enable && !ctrl.msg_mode && !hold;

   // Clock pin drive, high for one cycle per byte
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         video_clock_pin_o <= 1'b0;
         video_clock_pin_oe <= 1'b0;
      end else begin
         video_clock_pin_oe <= ctrl.clock_direction_bit;
         video_clock_pin_o <= ctrl.clock_direction_bit && vtick;
      end
   end

   // Line and frame counters; external lock waits for an edge
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hcnt <= '0;
         lcnt <= vou_pkg::FIRST_LINE;
         hold <= 1'b0;
      end else if (!ctrl.enable || ctrl.msg_mode) begin
         hcnt <= '0;
         lcnt <= vou_pkg::FIRST_LINE;
         hold <= 1'b1; // Held from enable, so a lock waits for its edge
      end else if (hold) begin
         if (fs_edge || !ext_lock) begin
            hold <= 1'b0;
         end
      end else begin
         if (vtick && line_end) begin
            hcnt <= '0;
            if (frame_end) begin
               lcnt <= vou_pkg::FIRST_LINE;
               hold <= ext_lock;
            end else begin
               lcnt <= lcnt + vou_pkg::UNIT12;
            end
         end else if (vtick) begin
            hcnt <= hcnt + vou_pkg::UNIT12;
         end
      end
   end

   // Byte selection: preamble, code, blanking or active video
   always_comb begin
      line_end = hcnt == line_bytes - vou_pkg::UNIT12;
      frame_end = lcnt >= frame_lines;
      field = lcnt >= field2_start;
      vblank = field ? (lcnt < f2_vline) : (lcnt < f1_vline);
      sidx = hcnt - (hs_start - vou_pkg::CODE_LEN);
      aidx = hcnt - hs_start;
      in_eav = hcnt < vou_pkg::CODE_LEN;
      in_sav = sidx < vou_pkg::CODE_LEN;
      in_act = hcnt >= hs_start;
      code = {1'b1, field, vblank, in_eav, vblank ^ in_eav, field ^ in_eav,
              field ^ vblank, field ^ vblank ^ in_eav};
      pre_idx = in_eav ? hcnt[1:0] : sidx[1:0];
      pair_end = in_act && !vblank && aidx[1:0] == vou_pkg::LAST_POS;
      case (aidx[1:0])
         vou_pkg::FF_POS: vidb = pix_in.u;
         vou_pkg::V_POS: vidb = pix_in.v;
         default: vidb = (ctrl.upscale ? dbl_half : aidx[1:0] == vou_pkg::LAST_POS)
                         ? pix_in.y1 : pix_in.y0;
      endcase
      case (aidx[1:0])
         vou_pkg::FF_POS: ovb = ovl_in.pix.u;
         vou_pkg::Y0_POS: ovb = ovl_in.pix.y0;
         vou_pkg::V_POS: ovb = ovl_in.pix.v;
         default: ovb = ovl_in.pix.y1;
      endcase
      a9 = 9'(ovl_in.alpha ? alpha1 : alpha0);
      if (a9 > vou_pkg::ALPHA_ONE) begin
         a9 = vou_pkg::ALPHA_ONE;
      end
      mix = (17'(a9) * 17'(ovb) + 17'(vou_pkg::ALPHA_ONE - a9) * 17'(vidb)) >> vou_pkg::BLEND_SH;
      active_byte = ctrl.overlay_en ? mix[7:0] : vidb;
      is_code = 1'b0;
      next_byte = hcnt[0] ? vou_pkg::BLANK_Y : vou_pkg::BLANK_C;
      if (in_eav || in_sav) begin
         case (pre_idx)
            vou_pkg::LAST_POS: begin
               next_byte = code;
               is_code = 1'b1;
            end
            vou_pkg::FF_POS: next_byte = vou_pkg::SYNC_FF;
            default: next_byte = vou_pkg::SYNC_00;
         endcase
      end else if (in_act && !vblank) begin
         next_byte = active_byte;
      end
   end

   // Horizontal doubling phase, reset each line
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dbl_half <= 1'b0;
      end else if (!run || !ctrl.upscale || (vtick && line_end)) begin
         dbl_half <= 1'b0;
      end else if (vtick && pair_end) begin
         dbl_half <= ~dbl_half;
      end
   end

   // Message sequencer, bytes sent in word order
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state <= vou_pkg::M_IDLE;
         words_left <= '0;
         bpos <= '0;
      end else begin
         case (state)
            vou_pkg::M_IDLE: begin
               if (msg_go && ctrl.msg_mode && ctrl.enable && msg_words != '0) begin
                  state <= vou_pkg::M_SEND;
                  words_left <= msg_words;
                  bpos <= '0;
               end
            end
            vou_pkg::M_SEND: begin
               if (!ctrl.msg_mode || !ctrl.enable) begin
                  state <= vou_pkg::M_IDLE;
               end else if (vtick) begin
                  bpos <= bpos + 2'(vou_pkg::UNIT12);
                  if (bpos == vou_pkg::LAST_POS) begin
                     words_left <= words_left - MSG_W'(vou_pkg::UNIT12);
                     if (msg_last) begin
                        state <= vou_pkg::M_DONE;
                     end
                  end
               end
            end
            vou_pkg::M_DONE: state <= vou_pkg::M_IDLE;
            default: state <= vou_pkg::M_IDLE;
         endcase
      end
   end

   // Message byte and last-byte detection
   always_comb begin
      msg_last = bpos == vou_pkg::LAST_POS && words_left == MSG_W'(vou_pkg::UNIT12);
      case (bpos)
         vou_pkg::FF_POS: msg_byte = pix_in.u;
         vou_pkg::Y0_POS: msg_byte = pix_in.y0;
         vou_pkg::V_POS: msg_byte = pix_in.v;
         default: msg_byte = pix_in.y1;
      endcase
   end

   // Output stage, everything changes only on a byte enable
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         video_byte_bus <= vou_pkg::SYNC_00;
         line_sync_or_msg_start_pin_o <= 1'b0;
         frame_sync_or_msg_end_pin_o <= 1'b0;
         code_out <= 1'b0;
      end else if (vtick) begin
         code_out <= 1'b0;
         if (ctrl.msg_mode) begin
            video_byte_bus <= (state == vou_pkg::M_SEND) ? msg_byte : vou_pkg::SYNC_00;
            line_sync_or_msg_start_pin_o <= state == vou_pkg::M_SEND && bpos == vou_pkg::FF_POS
                                            && words_left == msg_words;
            frame_sync_or_msg_end_pin_o <= state == vou_pkg::M_SEND && msg_last;
         end else begin
            // Frame sync only; retrace timing is the display's job
            video_byte_bus <= hold ? vou_pkg::BLANK_C : next_byte;
            code_out <= !hold && is_code;
            line_sync_or_msg_start_pin_o <= ctrl.hs_out_en && !in_act;
            frame_sync_or_msg_end_pin_o <= ctrl.fs_out_en && lcnt == vou_pkg::FIRST_LINE;
         end
      end
   end

   // Pin directions and one-cycle event pulses
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         line_sync_or_msg_start_pin_oe <= 1'b0;
         frame_sync_or_msg_end_pin_oe <= 1'b0;
         pix_take <= 1'b0;
         ovl_take <= 1'b0;
         loop_byte <= '0;
         loop_valid <= 1'b0;
         host_irq <= 1'b0;
      end else begin
         line_sync_or_msg_start_pin_oe <= ctrl.msg_mode || ctrl.hs_out_en;
         frame_sync_or_msg_end_pin_oe <= ctrl.msg_mode || (!ext_lock && ctrl.fs_out_en);
         pix_take <= vtick && ((run && pair_end && (!ctrl.upscale || dbl_half))
                     || (ctrl.msg_mode && state == vou_pkg::M_SEND && bpos == vou_pkg::LAST_POS));
         ovl_take <= vtick && run && pair_end && ctrl.overlay_en;
         loop_valid <= vtick && ctrl.loopback_select;
         if (vtick && ctrl.loopback_select) begin
            if (ctrl.msg_mode) begin
               loop_byte <= (state == vou_pkg::M_SEND) ? msg_byte : vou_pkg::SYNC_00;
            end else begin
               loop_byte <= hold ? vou_pkg::BLANK_C : next_byte;
            end
         end
         host_irq <= vtick && run && hcnt == '0
                     && ((ctrl.irq_field_en && (lcnt == vou_pkg::FIRST_LINE || lcnt == field2_start))
                     || (ctrl.irq_line_en && lcnt == irq_line));
      end
   end

   eav_lead_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (vtick && run && hcnt == '0) |=> video_byte_bus == vou_pkg::SYNC_FF)
      else $error("line does not open with the preamble");
   code_prot_a: assert property (@(posedge mclk) disable iff (!arst_n)
      code_out |-> video_byte_bus[7] && video_byte_bus[3:0] == {video_byte_bus[5] ^ video_byte_bus[4],
      video_byte_bus[6] ^ video_byte_bus[4], video_byte_bus[6] ^ video_byte_bus[5],
      ^video_byte_bus[6:4]})
      else $error("sync code protection bits wrong");
   clk_dir_a: assert property (@(posedge mclk) disable iff (!arst_n)
      ##1 video_clock_pin_oe == $past(ctrl.clock_direction_bit))
      else $error("clock pin direction wrong");
   hs_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (!ctrl.hs_out_en && !ctrl.msg_mode) |=> !line_sync_or_msg_start_pin_oe)
      else $error("line sync driven while disabled");
   fs_input_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (ext_lock && !ctrl.msg_mode) |=> !frame_sync_or_msg_end_pin_oe)
      else $error("frame sync pin driven in external lock");
   lock_wait_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (ext_lock && hold && ctrl.enable && !ctrl.msg_mode && !fs_edge && $stable(ctrl))
      |=> $stable(lcnt) && $stable(hcnt) && hold)
      else $error("timing moved without a frame sync edge");
   loop_copy_a: assert property (@(posedge mclk) disable iff (!arst_n)
      loop_valid |-> loop_byte == video_byte_bus)
      else $error("loopback byte differs from output");
   msg_end_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (vtick && ctrl.msg_mode && state == vou_pkg::M_SEND && msg_last)
      |=> frame_sync_or_msg_end_pin_o ##1 state == vou_pkg::M_IDLE)
      else $error("message end strobe missing");
   irq_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
      host_irq |-> $past(vtick) ##1 !host_irq)
      else $error("interrupt not a single pulse");
endmodule

// file: test/vou_far_end_model.sv
// Far-side model: external video clock and frame sync source
`timescale 1ns/1ps
module vou_far_end_model (
   input wire logic run,
   input wire logic fs_level,
   output logic video_clock,
   output logic frame_sync
);
   // Clock stands low while run is low, 50 MHz when running
   initial video_clock = 1'b0;
   always #10 video_clock = run ? ~video_clock : 1'b0;
   // Frame sync edge chosen by the bench
   assign frame_sync = fs_level;
endmodule

// file: test/test_video_output_unit.sv
// Bench for the video output unit
`timescale 1ns/1ps
module test_video_output_unit;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0, fs_level = 1'b0;
   logic ext_clk, ext_fs, clk_o, clk_oe, ls_o, ls_oe, fe_o, fe_oe, loop_valid, host_irq, pix_take;
   logic [7:0] bus, loop_byte, b;
   // Pixel source holds one pair, so no reload is due
   vou_pkg::vou_pix_type pix_in = 32'h11223344;
   vou_pkg::vou_ovl_type ovl_in = 33'h0;
   int n_errors = 0, checked = 0, irqs = 0;
   // 200 MHz clock and interrupt pulse counter
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) if (host_irq === 1'b1) irqs++;
   vou_video_output_unit vou_video_output_unit_inst (
      .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_in(pix_in),
      .ovl_in(ovl_in), .pix_take(pix_take), .ovl_take(), .video_byte_bus(bus),
      .video_clock_pin_i(clk_oe ? clk_o : ext_clk), .video_clock_pin_o(clk_o),
      .video_clock_pin_oe(clk_oe), .line_sync_or_msg_start_pin_o(ls_o),
      .line_sync_or_msg_start_pin_oe(ls_oe),
      .frame_sync_or_msg_end_pin_i(fe_oe ? fe_o : ext_fs),
      .frame_sync_or_msg_end_pin_o(fe_o), .frame_sync_or_msg_end_pin_oe(fe_oe),
      .loop_byte(loop_byte), .loop_valid(loop_valid), .host_irq(host_irq));
   vou_far_end_model vou_far_end_model_inst (
      .run(run), .fs_level(fs_level), .video_clock(ext_clk), .frame_sync(ext_fs));
   // Verdict and end of run
   task automatic close_out;
      $display("Counts: %0d compared, %0d mismatched", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Register bus cycles
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [5:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata;
   endtask
   task automatic do_reset;
      arst_n <= 1'b0;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
   endtask
   // Wait for the next output clock pulse, then take the byte
   task automatic next_byte;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (clk_o !== 1'b1 && n < 400);
      if (n >= 400) check("byte wait", 0, 1);
      b = bus;
   endtask
   // Expected byte of line n, position h, for the small test frame
   function automatic logic [7:0] exp_byte(input int n, input int h);
      logic f, v, e;
      f = (n >= 3);
      v = !(n == 2 || n >= 4);
      e = (h < 4);
      if (h < 12 && !(h >= 4 && h < 8)) begin
         if (h % 4 == 0) return vou_pkg::SYNC_FF;
         if (h % 4 != 3) return vou_pkg::SYNC_00;
         return {1'b1, f, v, e, v ^ e, f ^ e, f ^ v, f ^ v ^ e};
      end
      if (h >= 12 && !v) return pix_in[31 - 8 * (h % 4) -: 8];
      return (h % 2) ? vou_pkg::BLANK_Y : vou_pkg::BLANK_C;
   endfunction
   initial begin
      #200000;
      n_errors++;
      close_out;
   end
   initial begin
      do_reset;
      check("clock pin oe", 0, 32'(clk_oe));
      rd(vou_pkg::A_FRAME);
      check("frame reset", {4'h0, vou_pkg::RST_LBYTES, 4'h0, vou_pkg::RST_LINES}, d);
      @(posedge mclk);
      check("rdata after", 0, reg_rdata);
      wr(6'h3c, 32'hffffffff);
      rd(6'h3c);
      check("unmapped", 0, d);
      $display("test registers done");
      // Message of one word, legacy synth rate, loopback on
      wr(vou_pkg::A_SYNTH, 32'h2aaaaaaa);
      wr(vou_pkg::A_CTRL, 32'h33);
      @(posedge mclk);
      check("clock pin oe", 1, 32'(clk_oe));
      wr(vou_pkg::A_MSG, 32'h1);
      for (int i = 0; i < 4; i++) begin
         next_byte;
         check("msg byte", 32'(pix_in[31 - 8 * i -: 8]), 32'(b));
         check("msg start", 32'(i == 0), 32'(ls_o));
         check("msg end", 32'(i == 3), 32'(fe_o));
         check("loop byte", 32'(pix_in[31 - 8 * i -: 8]), 32'(loop_byte));
         check("loop valid", 1, 32'(loop_valid));
         check("pix take", 32'(i == 3), 32'(pix_take));
      end
      $display("test message done");
      // Small internally timed frame: 4 lines of 16 bytes
      do_reset;
      wr(vou_pkg::A_FRAME, 32'h00100004);
      wr(vou_pkg::A_FIELD, 32'h000c0003);
      wr(vou_pkg::A_VLINE, 32'h00040002);
      irqs = 0;
      wr(vou_pkg::A_CTRL, 32'h8d5); // Overlay off, so no rate limit
      // Rate set last, so no byte goes by before the loop looks
      wr(vou_pkg::A_SYNTH, 32'h8e38e38e);
      for (int n = 1; n <= 4; n++) begin
         for (int h = 0; h < 16; h++) begin
            next_byte;
            check("video byte", 32'(exp_byte(n, h)), 32'(b));
            check("line sync", 32'(h < 12), 32'(ls_o));
            check("frame sync", 32'(n == 1), 32'(fe_o));
         end
      end
      check("irq count", 2, irqs);
      $display("test video done");
      // External clock and frame lock, rising edge selected
      do_reset;
      wr(vou_pkg::A_FRAME, 32'h00100004);
      wr(vou_pkg::A_FIELD, 32'h000c0003);
      wr(vou_pkg::A_VLINE, 32'h00040002);
      run <= 1'b1;
      wr(vou_pkg::A_CTRL, 32'h109);
      repeat (40) @(posedge mclk);
      rd(vou_pkg::A_STAT);
      check("waiting", 1, 32'(d[18]));
      check("idle bus", 32'h80, 32'(bus));
      check("fs pin oe", 0, 32'(fe_oe));
      check("ls pin oe", 0, 32'(ls_oe));
      fs_level <= 1'b1;
      repeat (190) @(posedge mclk);
      rd(vou_pkg::A_STAT);
      check("second field", 32'h1, 32'(d[18:16]));
      repeat (600) @(posedge mclk);
      fs_level <= 1'b0;
      repeat (100) @(posedge mclk);
      rd(vou_pkg::A_STAT);
      check("waits again", 1, 32'(d[18]));
      $display("test lock done");
      close_out;
   end
endmodule
